// ===== rtl/pasd_params.svh
// Offsets, field positions, masks and reset values of the shutdown block.
// Included by the package; holds definitions only.
`ifndef PASD_PARAMS_SVH
`define PASD_PARAMS_SVH

// ==========================================================
// Register byte offsets on the APB
`define PASD_ADDR_W        12
`define PASD_OFF_CTRL      12'h000
`define PASD_OFF_LEVEL     12'h004
`define PASD_OFF_SRC       12'h008
`define PASD_OFF_IRQ_STAT  12'h00C
`define PASD_OFF_IRQ_MASK  12'h010

// ==========================================================
// Word index of each register (byte offset bits 4:2)
`define PASD_IDX_CTRL      3'h0
`define PASD_IDX_LEVEL     3'h1
`define PASD_IDX_SRC       3'h2
`define PASD_IDX_IRQ_STAT  3'h3
`define PASD_IDX_IRQ_MASK  3'h4

// ==========================================================
// Field positions
`define PASD_CTRL_STAT     7
`define PASD_CTRL_EN       6
`define PASD_CTRL_ARS      5
`define PASD_CTRL_OVR      0
`define PASD_SRC_PIN       7
`define PASD_SRC_CMP_HI    4
`define PASD_SRC_CMP_LO    1
`define PASD_IRQ_SHDN      0

// ==========================================================
// Implemented-bit masks and reset values
`define PASD_LVL_ALL_MASK  6'h3F
`define PASD_LVL_AB_MASK   6'h03
`define PASD_RST_CTRL      8'h00
`define PASD_RST_LEVEL     6'h00
`define PASD_RST_SRC       5'h00
`define PASD_RST_IRQ       1'h0

`endif

// ===== rtl/pasd_pkg.sv
// Types shared by the shutdown block's modules.
// Assumes pasd_params.svh is on the include path.
`default_nettype none

`include "pasd_params.svh"

package pasd_pkg;

  typedef enum {
    PASD_RUN,
    PASD_SHUT
  } pasd_state_t;

  // Register request decoded from one APB access phase
  typedef struct packed {
    logic       wr;
    logic [2:0] idx;
    logic [7:0] wdata;
  } pasd_req_t;

  // Synchronised shutdown sources
  typedef struct packed {
    logic       pin;
    logic [3:0] cmp;
  } pasd_src_t;

endpackage : pasd_pkg

`default_nettype wire

// ===== rtl/pasd_sync.sv
// Three-flop input synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk_in; out changes once stages 2 and 3 agree.
`default_nettype none

module pasd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output var  logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  wire  [WIDTH-1:0] agree = ~(s2_q ^ s3_q);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      q_out <= '0;
    end else begin
      s1_q  <= d_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      // A single-cycle glitch never reaches the output
      q_out <= (agree & s3_q) | (~agree & q_out);
    end
  end

endmodule // pasd_sync

`default_nettype wire

// ===== rtl/pasd_apb.sv
// APB slave front end of the shutdown block: decode, ready, read data, error.
// Assumes a standard APB master; every access completes with no wait state.
`default_nettype none

`include "pasd_params.svh"

module pasd_apb
  import pasd_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [`PASD_ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]            pwdata_in,
  input  wire logic [7:0]             rdata_in,
  output var  pasd_req_t              req_out,
  output var  logic [2:0]             rd_idx_out,
  output var  logic                   pready_out,
  output var  logic [31:0]            prdata_out,
  output var  logic                   pslverr_out
);

  wire setup  = psel_in & ~penable_in;
  wire access = psel_in & penable_in & pready_out;
  wire hit    = (paddr_in == `PASD_OFF_CTRL)     | (paddr_in == `PASD_OFF_LEVEL) |
                (paddr_in == `PASD_OFF_SRC)      | (paddr_in == `PASD_OFF_IRQ_STAT) |
                (paddr_in == `PASD_OFF_IRQ_MASK);

  assign rd_idx_out    = paddr_in[4:2];
  assign req_out.idx   = paddr_in[4:2];
  assign req_out.wdata = pwdata_in[7:0];
  // Unmapped writes are dropped and flagged
  assign req_out.wr    = access & pwrite_in & hit;

  // ==========================================================
  // Answer is prepared in the setup cycle, so pready is a flop
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_out  <= 1'h0;
      pslverr_out <= 1'h0;
      prdata_out  <= 32'h0;
    end else begin
      pready_out  <= setup;
      pslverr_out <= setup & ~hit;
      prdata_out  <= (setup & ~pwrite_in & hit) ? {24'h0, rdata_in} : 32'h0;
    end
  end

endmodule // pasd_apb

`default_nettype wire

// ===== rtl/pasd_top.sv
// Auto-shutdown control of one PWM controller instance, with APB registers.
// Assumes PWM_IN comes from logic on CLK_IN; pin and comparator inputs are async.
//
// How it works
// [RULE_01] While the status bit is set the outputs sit at their shutdown levels, else follow PWM.
// [RULE_02] With shutdown enabled, any selected source high shuts down and sets the flag.
// [RULE_03] With auto restart, shutdown ends by itself once no enabled source is high.
// [RULE_04] Without auto restart, shutdown lasts until software writes the status bit to 0.
// [RULE_05] Enable plus override forces the shutdown levels without raising the flag.
// [RULE_06] The override bit does nothing while shutdown is disabled.
// [RULE_07] Software writing 1 to the status bit acts exactly like a hardware event.
// [RULE_08] In shutdown, output n drives level bit n, bits 0 to 5 for outputs A to F.
// [RULE_09] On the second instance only outputs A and B have level bits.
// [RULE_10] The input pin causes shutdown only when its select bit is set.
// [RULE_11] Each comparator, select bits 1 to 4, causes shutdown only when selected.
// [RULE_12] Unimplemented bits of control, level and source registers read as zero.
// [RULE_13] Enabled sources are ORed; one is enough to cause or hold shutdown.
// [RULE_14] Auto restart clears the status bit itself; otherwise only software clears it.
//
// Implementation choices: the APB register port and the address map.
`default_nettype none

`include "pasd_params.svh"

module pasd_top
  import pasd_pkg::*;
#(
  parameter bit SECOND_INSTANCE = 1'b0
) (
  input  wire logic                    CLK_IN,
  input  wire logic                    RST_IN,
  input  wire logic                    PSEL_IN,
  input  wire logic                    PENABLE_IN,
  input  wire logic                    PWRITE_IN,
  input  wire logic [`PASD_ADDR_W-1:0] PADDR_IN,
  input  wire logic [31:0]             PWDATA_IN,
  input  wire logic                    EXTERNAL_EVENT_INPUT_IN,
  input  wire logic [3:0]              SYNCED_COMPARATOR_OUT_IN,
  input  wire logic [5:0]              PWM_IN,
  output var  logic                    PREADY_OUT,
  output var  logic [31:0]             PRDATA_OUT,
  output var  logic                    PSLVERR_OUT,
  output var  logic [5:0]              PWM_OUTPUT_OUT,
  output var  logic                    IRQ_OUT
);

  // ==========================================================
  // Register bus
  pasd_req_t  req;
  logic [2:0] rd_idx;
  logic [7:0] rd_data;

  pasd_apb u_apb (
    .clk_in      (CLK_IN),
    .rst_in      (RST_IN),
    .psel_in     (PSEL_IN),
    .penable_in  (PENABLE_IN),
    .pwrite_in   (PWRITE_IN),
    .paddr_in    (PADDR_IN),
    .pwdata_in   (PWDATA_IN),
    .rdata_in    (rd_data),
    .req_out     (req),
    .rd_idx_out  (rd_idx),
    .pready_out  (PREADY_OUT),
    .prdata_out  (PRDATA_OUT),
    .pslverr_out (PSLVERR_OUT)
  );

  wire wr_ctrl  = req.wr & (req.idx == `PASD_IDX_CTRL);
  wire wr_level = req.wr & (req.idx == `PASD_IDX_LEVEL);
  wire wr_src   = req.wr & (req.idx == `PASD_IDX_SRC);
  wire wr_stat  = req.wr & (req.idx == `PASD_IDX_IRQ_STAT);
  wire wr_mask  = req.wr & (req.idx == `PASD_IDX_IRQ_MASK);

  // ==========================================================
  // Source synchronisation
  pasd_src_t src_s;

  pasd_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk_in (CLK_IN),
    .rst_in (RST_IN),
    .d_in   ({EXTERNAL_EVENT_INPUT_IN, SYNCED_COMPARATOR_OUT_IN}),
    .q_out  (src_s)
  );

  // ==========================================================
  // Configuration registers
  logic       shutdown_enable_q;
  logic       auto_restart_enable_q;
  logic       shutdown_override_q;
  logic [5:0] level_q;
  logic       input_pin_select_q;
  logic [3:0] comp_select_q;
  logic       irq_mask_q;

  // Level bits C to F do not exist on the second instance
  localparam logic [5:0] LVL_MASK = SECOND_INSTANCE ? `PASD_LVL_AB_MASK
                                                    : `PASD_LVL_ALL_MASK;

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      shutdown_enable_q     <= 1'h0;
      auto_restart_enable_q <= 1'h0;
      shutdown_override_q   <= 1'h0;
    end else if (wr_ctrl) begin
      shutdown_enable_q     <= req.wdata[`PASD_CTRL_EN];
      auto_restart_enable_q <= req.wdata[`PASD_CTRL_ARS];
      shutdown_override_q   <= req.wdata[`PASD_CTRL_OVR];
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      level_q <= `PASD_RST_LEVEL;
    end else if (wr_level) begin
      // [RULE_09] missing level bits
      level_q <= req.wdata[5:0] & LVL_MASK;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      {input_pin_select_q, comp_select_q} <= `PASD_RST_SRC;
    end else if (wr_src) begin
      input_pin_select_q <= req.wdata[`PASD_SRC_PIN];
      comp_select_q      <= req.wdata[`PASD_SRC_CMP_HI:`PASD_SRC_CMP_LO];
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      irq_mask_q <= `PASD_RST_IRQ;
    end else if (wr_mask) begin
      irq_mask_q <= req.wdata[`PASD_IRQ_SHDN];
    end
  end

  // ==========================================================
  // Source combination
  // [RULE_10] pin source gate
  wire pin_hit = input_pin_select_q & src_s.pin;
  // [RULE_11] comparator source gates
  wire cmp_hit = |(comp_select_q & src_s.cmp);
  // [RULE_13] sources ORed
  // [RULE_02] enable gates all sources
  wire src_hit = shutdown_enable_q & (pin_hit | cmp_hit);

  // [RULE_07] software set as event
  wire sw_set   = wr_ctrl & req.wdata[`PASD_CTRL_STAT];
  // [RULE_04] software clear
  wire sw_clr   = wr_ctrl & ~req.wdata[`PASD_CTRL_STAT];
  wire shdn_set = src_hit | sw_set;
  // [RULE_03] auto restart on release
  wire auto_clr = auto_restart_enable_q & ~src_hit;

  // ==========================================================
  // Shutdown state
  pasd_state_t state_q;
  pasd_state_t state_d;

  // A set in the same cycle as a clear always wins, so no event is lost
  always_comb begin
    state_d = state_q;
    case (state_q)
      PASD_RUN: begin
        if (shdn_set) begin
          state_d = PASD_SHUT;
        end
      end
      PASD_SHUT: begin
        // [RULE_14] who may leave shutdown
        if (!shdn_set && (auto_clr || sw_clr)) begin
          state_d = PASD_RUN;
        end
      end
      default: begin
        state_d = PASD_SHUT;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_q <= PASD_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  wire shut_stat = (state_q == PASD_SHUT);

  // ==========================================================
  // Interrupt flag, write one to clear
  logic irq_stat_q;

  wire stat_clr = wr_stat & req.wdata[`PASD_IRQ_SHDN];
  // [RULE_02] flag raised by events
  wire irq_stat_d = shdn_set | (irq_stat_q & ~stat_clr);

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      irq_stat_q <= `PASD_RST_IRQ;
      IRQ_OUT    <= 1'h0;
    end else begin
      irq_stat_q <= irq_stat_d;
      IRQ_OUT    <= irq_stat_d & irq_mask_q;
    end
  end

  // ==========================================================
  // Output steering
  // [RULE_05] override forces levels, no flag
  // [RULE_06] override needs enable
  wire ovr_force = shutdown_enable_q & shutdown_override_q;
  // [RULE_01] hold shutdown levels
  wire force_lvl = shut_stat | ovr_force;

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PWM_OUTPUT_OUT <= `PASD_RST_LEVEL;
    end else begin
      // [RULE_08] per-output level
      PWM_OUTPUT_OUT <= force_lvl ? level_q : PWM_IN;
    end
  end

  // ==========================================================
  // Read mux
  // [RULE_12] unimplemented bits read zero
  wire [7:0] rd_ctrl  = {shut_stat, shutdown_enable_q, auto_restart_enable_q,
                         4'h0, shutdown_override_q};
  wire [7:0] rd_level = {2'h0, level_q};
  wire [7:0] rd_src   = {input_pin_select_q, 2'h0, comp_select_q, 1'h0};
  wire [7:0] rd_stat  = {7'h0, irq_stat_q};
  wire [7:0] rd_mask  = {7'h0, irq_mask_q};

  assign rd_data = (rd_idx == `PASD_IDX_CTRL)     ? rd_ctrl  :
                   (rd_idx == `PASD_IDX_LEVEL)    ? rd_level :
                   (rd_idx == `PASD_IDX_SRC)      ? rd_src   :
                   (rd_idx == `PASD_IDX_IRQ_STAT) ? rd_stat  :
                   (rd_idx == `PASD_IDX_IRQ_MASK) ? rd_mask  : 8'h00;

endmodule // pasd_top

`default_nettype wire

// ===== tb/pasd_props.sv
// Port checker of the shutdown block: APB answer, forcing, sources, interrupt.
// Assumes binding to pasd_top with default parameters; sees ports only.
`default_nettype none
`include "pasd_params.svh"
module pasd_props (
  input wire logic        CLK_IN,
  input wire logic        RST_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic        EXTERNAL_EVENT_INPUT_IN,
  input wire logic [3:0]  SYNCED_COMPARATOR_OUT_IN,
  input wire logic [5:0]  PWM_IN,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic [5:0]  PWM_OUTPUT_OUT,
  input wire logic        IRQ_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // ==========================================
  // Register shadow from completed writes
  logic       wr_ok;
  logic       hit;
  logic       frc;
  logic [7:0] ctl_q, lvl_q, sel_q;
  logic       msk_q;
  assign wr_ok = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
  assign frc   = ctl_q[6] && ctl_q[0];
  // Raw inputs, so a hit must be held past the synchroniser delay
  assign hit   = ctl_q[6] && ((sel_q[7] && EXTERNAL_EVENT_INPUT_IN) ||
                 (|(sel_q[4:1] & SYNCED_COMPARATOR_OUT_IN)));
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      {ctl_q, lvl_q, sel_q, msk_q} <= 25'h0000000;
    end else if (wr_ok) begin
      if (PADDR_IN == `PASD_OFF_CTRL) ctl_q <= PWDATA_IN[7:0];
      if (PADDR_IN == `PASD_OFF_LEVEL) lvl_q <= PWDATA_IN[7:0];
      if (PADDR_IN == `PASD_OFF_SRC) sel_q <= PWDATA_IN[7:0];
      if (PADDR_IN == `PASD_OFF_IRQ_MASK) msk_q <= PWDATA_IN[0];
    end
  end
  sequence s_forced; (frc && $stable(lvl_q)) [*3]; endsequence
  sequence s_held; (hit && $stable(lvl_q)) [*8]; endsequence
  sequence s_clear;
    wr_ok && PADDR_IN == `PASD_OFF_CTRL && !PWDATA_IN[7] ##1 (!hit && !frc) [*2];
  endsequence
  a_ready_setup: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
    else $error("no ready after setup");
  a_ready_single: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready too long");
  a_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
  a_force_levels: assert property (s_forced |-> PWM_OUTPUT_OUT == lvl_q[5:0])
    else $error("override levels wrong");
  a_src_shuts: assert property (s_held |-> PWM_OUTPUT_OUT == lvl_q[5:0])
    else $error("source did not shut down");
  a_src_irq: assert property (s_held ##0 msk_q |-> IRQ_OUT)
    else $error("irq missing");
  a_mask_quiet: assert property (!msk_q && !$past(msk_q) |-> !IRQ_OUT)
    else $error("masked irq high");
  a_clear_follows: assert property (s_clear |-> PWM_OUTPUT_OUT == $past(PWM_IN))
    else $error("pwm not resumed");
endmodule // pasd_props
`default_nettype wire

// ===== tb/pasd_plant.sv
// Far-side model: comparators and shutdown pin on bench command, and a PWM source.
// Assumes one clock; every output changes just after its rising edge.
`default_nettype none
module pasd_plant (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [4:0] trip_in,
  output var  logic       pin_out,
  output var  logic [3:0] cmp_out,
  output var  logic [5:0] pwm_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Trip lines and PWM source
  // Even codes only, so an odd shutdown level is never mistaken for PWM
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      {pin_out, cmp_out, pwm_out} <= 11'h000;
    end else begin
      {pin_out, cmp_out} <= trip_in;
      pwm_out <= pwm_out + 6'h02;
    end
  end
endmodule // pasd_plant
`default_nettype wire

// ===== tb/test_pasd_top.sv
// Bench of the shutdown block: registers, override, sources, restart, interrupt.
// Assumes package, design, plant model and checker compiled before it.
`default_nettype none
`include "pasd_params.svh"
module test_pasd_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] ctl_a = `PASD_OFF_CTRL;
  localparam logic [11:0] lvl_a = `PASD_OFF_LEVEL;
  localparam logic [11:0] src_a = `PASD_OFF_SRC;
  localparam logic [11:0] ist_a = `PASD_OFF_IRQ_STAT;
  localparam logic [11:0] msk_a = `PASD_OFF_IRQ_MASK;
  logic        clk, rst, psel, pen, pwr, pready, pslverr, irq, pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0]  trip;
  logic [3:0]  cmp;
  logic [5:0]  pwm, pwm_prev, pout;
  int          error_cnt, num_checks, cyc;
  pasd_top dut (
    .CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .EXTERNAL_EVENT_INPUT_IN(pin),
    .SYNCED_COMPARATOR_OUT_IN(cmp), .PWM_IN(pwm), .PREADY_OUT(pready),
    .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr), .PWM_OUTPUT_OUT(pout), .IRQ_OUT(irq));
  pasd_plant plant (
    .clk_in(clk), .rst_in(rst), .trip_in(trip), .pin_out(pin), .cmp_out(cmp), .pwm_out(pwm));
  // ==========================================
  // Clock, timeout and shared tasks
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) pwm_prev <= pwm;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    num_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, 24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    // Waits for the answer; only the bench timeout ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = {pslverr, prdata[30:0]};
    {psel, pen} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic e);
    logic [31:0] r;
    apb(1'b0, a, 8'h00, r);
    chk(r, {e, 23'h000000, x}, "read");
  endtask
  task automatic settle(input logic shut, input logic [5:0] lv);
    for (int n = 0; n < 16 && pout !== (shut ? lv : pwm_prev); n++) @(negedge clk);
    repeat (2) begin
      @(negedge clk);
      chk(32'(pout), 32'(shut ? lv : pwm_prev), "pwm out");
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] r;
    rd(ctl_a, 8'h00, 1'b0);
    rd(lvl_a, 8'h00, 1'b0);
    rd(src_a, 8'h00, 1'b0);
    wr(lvl_a, 8'hFF);
    rd(lvl_a, 8'h3F, 1'b0);
    wr(src_a, 8'hFF);
    rd(src_a, 8'h9E, 1'b0);
    wr(ctl_a, 8'h1E);
    rd(ctl_a, 8'h00, 1'b0);
    apb(1'b1, 12'h014, 8'hFF, r);
    chk(r, 32'h80000000, "unmapped write");
    rd(12'h014, 8'h00, 1'b1);
  endtask
  task automatic t_override();
    wr(lvl_a, 8'h2D);
    wr(ctl_a, 8'h41);
    settle(1'b1, 6'h2D);
    rd(ist_a, 8'h00, 1'b0);
    wr(ctl_a, 8'h01);
    settle(1'b0, 6'h00);
  endtask
  task automatic t_sources();
    int k;
    wr(msk_a, 8'h01);
    for (int i = 0; i < 5; i++) begin
      k = (i + 1) % 5;
      wr(src_a, (i == 4) ? 8'h80 : 8'h02 << i);
      wr(ctl_a, 8'h60);
      trip <= 5'h01 << k;
      repeat (10) @(posedge clk);
      settle(1'b0, 6'h00);
      trip <= (5'h01 << k) | (5'h01 << i);
      settle(1'b1, 6'h2D);
      chk(32'(irq), 32'h1, "irq up");
      rd(ctl_a, 8'hE0, 1'b0);
      trip <= 5'h00;
      settle(1'b0, 6'h00);
      rd(ctl_a, 8'h60, 1'b0);
      wr(ist_a, 8'h01);
      repeat (2) @(negedge clk);
      chk(32'(irq), 32'h0, "irq cleared");
    end
  endtask
  task automatic t_latch();
    wr(msk_a, 8'h00);
    wr(src_a, 8'h86);
    trip <= 5'h11;
    settle(1'b1, 6'h2D);
    trip <= 5'h01;
    repeat (10) @(posedge clk);
    settle(1'b1, 6'h2D);
    wr(ctl_a, 8'hC0);
    trip <= 5'h00;
    repeat (10) @(posedge clk);
    settle(1'b1, 6'h2D);
    chk(32'(irq), 32'h0, "irq masked");
    rd(ctl_a, 8'hC0, 1'b0);
    wr(ctl_a, 8'h40);
    settle(1'b0, 6'h00);
    // Flag cleared first, so the software set must raise it again
    wr(ist_a, 8'h01);
    rd(ist_a, 8'h00, 1'b0);
    wr(ctl_a, 8'hC0);
    settle(1'b1, 6'h2D);
    rd(ist_a, 8'h01, 1'b0);
    wr(ctl_a, 8'h40);
    settle(1'b0, 6'h00);
  endtask
  task automatic t_disabled();
    wr(src_a, 8'h9E);
    wr(ctl_a, 8'h21);
    trip <= 5'h1F;
    repeat (12) @(posedge clk);
    settle(1'b0, 6'h00);
    rd(ctl_a, 8'h21, 1'b0);
    trip <= 5'h00;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {rst, psel, pen, pwr, paddr, pwdata, trip} <= {1'b1, 52'h0};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_override();
    t_sources();
    t_latch();
    t_disabled();
    finish_test();
  end
endmodule // test_pasd_top
bind pasd_top pasd_props u_props (.*);
`default_nettype wire
